// File: rtl/iba_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module iba_arbiter
    import iba_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    input  wire iba_mreq_type        mreq_i [IBA_NM],
    input  wire logic                sleep_i,
    input  wire logic                pclk_en_i,
    input  wire logic                ext_bus_request_in_n_i,
    input  wire iba_acc_type         acc_i,
    output logic                     acc_ready_o,
    output logic                     acc_done_o,
    output logic                     pbuf_busy_o,
    output logic      [IBA_NM-1:0]   int_gnt_o,
    output logic      [IBA_NM-1:0]   ext_gnt_o,
    output iba_pins_type             pins_o
);

    // ======================================================
    // Software registers.
    logic       ext_write_buffer_enable_r;
    logic       bus_release_enable_r;
    logic       periph_write_buffer_enable_r;
    logic       cpu_cycle_share_r;
    logic       pin_input_control_r;
    logic [31:0] rdata_r;

    typedef enum logic [2:0] {
        EXT_IDLE = 3'b001,
        EXT_MAST = 3'b010,
        EXT_REL  = 3'b100
    } iba_ext_type;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_SYS  = 3'b010,
        ENG_PER  = 3'b100
    } iba_eng_type;

    // Highest set bit wins; DMA sits at the top index.
    function automatic logic [IBA_NM-1:0] pick(input logic [IBA_NM-1:0] r);
        logic [IBA_NM-1:0] g;
        g = '0;
        for (int i = 0; i < IBA_NM; i++) begin
            if (r[i]) begin
                g = '0;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    // ======================================================
    // Internal arbiter.
    logic [IBA_NM-1:0] req_w;
    logic [IBA_NM-1:0] ext_w;
    logic [IBA_NM-1:0] end_w;
    logic [IBA_NM-1:0] lock_w;
    logic [IBA_NM-1:0] hold_w;
    logic [IBA_NM-1:0] wr_w;

    genvar gi;
    generate
        for (gi = 0; gi < IBA_NM; gi++) begin : g_unpack
            assign req_w[gi]  = mreq_i[gi].req;
            assign ext_w[gi]  = mreq_i[gi].ext;
            assign end_w[gi]  = mreq_i[gi].cyc_end;
            assign lock_w[gi] = mreq_i[gi].lock;
            assign hold_w[gi] = mreq_i[gi].hold;
            assign wr_w[gi]   = mreq_i[gi].wr;
        end
    endgenerate

    logic [IBA_NM-1:0] gnt_r;
    logic [IBA_NM-1:0] gnt_nxt;
    logic              cpu_held;
    logic              ctl_held;
    logic              holder_req;
    logic              holder_end;
    logic              holder_lock;
    logic              may_switch;
    logic              share_turn;
    logic              dma_keep;
    logic [IBA_NM-1:0] winner;

    assign cpu_held    = gnt_r[IBA_M_CPU];
    assign ctl_held    = gnt_r[IBA_M_DTC] | gnt_r[IBA_M_DMA];
    assign holder_req  = |(gnt_r & req_w);
    // In sleep the processor has no cycle to finish and yields on any edge unless locked.
    assign holder_end  = |(gnt_r & end_w) | (cpu_held & sleep_i);
    // Locked phases come from the masters' sequencers.
    assign holder_lock = |(gnt_r & lock_w);
    assign may_switch  = holder_end & ~holder_lock;
    // After a controller cycle the processor gets the next one.
    assign share_turn  = cpu_cycle_share_r & ctl_held & req_w[IBA_M_CPU];
    // Block and burst keep the bus only while sharing is off.
    assign dma_keep    = gnt_r[IBA_M_DMA] & hold_w[IBA_M_DMA] & ~cpu_cycle_share_r;
    assign winner      = share_turn ? (IBA_NM'(1) << IBA_M_CPU) : pick(req_w);

    // A holder that drops its request frees the bus at once.
    always_comb begin
        gnt_nxt = gnt_r;
        if (!holder_req) begin
            gnt_nxt = pick(req_w);
        end else if (may_switch && !dma_keep) begin
            gnt_nxt = winner;
        end
    end

    // ======================================================
    // External arbiter.
    iba_ext_type ext_r;
    iba_ext_type ext_nxt;
    logic        rel_req;
    logic        ext_want;
    logic        ext_done;
    logic [2:0]  ext_wr_cnt_r;
    logic        ext_wr_act;

    // Only an enabled and routed pin forwards the request.
    assign rel_req  = ~ext_bus_request_in_n_i & bus_release_enable_r
                      & pin_input_control_r;
    // Only the internal holder may ask for the external bus.
    assign ext_want = |(gnt_r & req_w & ext_w);
    assign ext_done = holder_end | ~ext_want;

    always_comb begin
        ext_nxt = ext_r;
        case (ext_r)
            EXT_IDLE: begin
                if (rel_req) begin
                    ext_nxt = EXT_REL;
                end else if (ext_want) begin
                    ext_nxt = EXT_MAST;
                end
            end
            EXT_MAST: begin
                // Release only after the running external cycle ends.
                if (ext_done) begin
                    ext_nxt = rel_req ? EXT_REL : EXT_IDLE;
                end
            end
            EXT_REL: begin
                if (!rel_req) begin
                    ext_nxt = EXT_IDLE;
                end
            end
            default: ext_nxt = EXT_IDLE;
        endcase
    end

    assign ext_wr_act = (ext_r == EXT_MAST) & |(gnt_r & wr_w);

    // ======================================================
    // Access timing engine.
    iba_eng_type eng_r;
    iba_eng_type eng_nxt;
    logic [2:0]  cnt_r;
    logic [2:0]  cnt_nxt;
    logic [2:0]  need_r;
    logic [2:0]  need_w;
    logic        per_sp;
    logic        sys_sp;
    logic        buf_ok;
    logic        buf_w;
    logic        solo_r;
    logic [2:0]  pb_cnt_r;
    logic [2:0]  pb_need_r;
    logic        pb_busy_r;
    logic        ext_blk;
    logic        pb_blk;
    logic        start;
    logic        done_w;

    assign per_sp = (acc_i.space == IBA_SP_PFW) | (acc_i.space == IBA_SP_PER);
    assign sys_sp = ~per_sp;

    always_comb begin
        case (acc_i.space)
            IBA_SP_ROM: need_w = acc_i.wr ? IBA_ROM_WR : IBA_ROM_RD;
            IBA_SP_RAM: need_w = acc_i.wr ? IBA_RAM_WR : IBA_RAM_RD;
            IBA_SP_SYS: need_w = acc_i.wr ? IBA_SYS_WR : IBA_SYS_RD;
            IBA_SP_PFW: need_w = acc_i.wr ? IBA_PFW_WR : IBA_PFW_RD;
            IBA_SP_PER: need_w = acc_i.wr ? IBA_PER_WR : IBA_PER_RD;
            default:    need_w = IBA_CNT_ONE;
        endcase
    end

    // Only the bufferable peripheral class may use the write buffer.
    assign buf_w  = (acc_i.space == IBA_SP_PER) & acc_i.wr
                    & periph_write_buffer_enable_r;
    // An internal access waits on an external write unless buffered and the write has run IBA_SOLO_CYC cycles.
    assign buf_ok = ext_write_buffer_enable_r & (ext_wr_cnt_r >= IBA_SOLO_CYC);
    assign ext_blk = ext_wr_act & (acc_i.space != IBA_SP_EXT) & ~buf_ok;
    // A buffered peripheral write keeps the peripheral bus to itself.
    assign pb_blk  = pb_busy_r & per_sp;
    assign acc_ready_o = (eng_r == ENG_IDLE) & ~ext_blk & ~pb_blk;
    assign start       = acc_i.valid & acc_ready_o;

    // Peripheral counts wait for clock enables, adding 0 to n-1 sync cycles.
    always_comb begin
        eng_nxt = eng_r;
        cnt_nxt = cnt_r;
        done_w  = 1'b0;
        case (eng_r)
            ENG_IDLE: begin
                cnt_nxt = IBA_CNT_ZERO;
                if (start) begin
                    eng_nxt = sys_sp ? ENG_SYS : ENG_PER;
                    if (sys_sp || buf_w) begin
                        cnt_nxt = IBA_CNT_ONE;
                    end
                    if (sys_sp && need_w == IBA_CNT_ONE) begin
                        eng_nxt = ENG_IDLE;
                        done_w  = 1'b1;
                    end
                end
            end
            ENG_SYS: begin
                cnt_nxt = cnt_r + IBA_CNT_ONE;
                if (cnt_nxt == need_r) begin
                    eng_nxt = ENG_IDLE;
                    done_w  = 1'b1;
                end
            end
            ENG_PER: begin
                // Buffered write runs alone for two system cycles.
                if (solo_r) begin
                    cnt_nxt = cnt_r + IBA_CNT_ONE;
                    if (cnt_nxt == IBA_SOLO_CYC) begin
                        eng_nxt = ENG_IDLE;
                        done_w  = 1'b1;
                    end
                end else if (pclk_en_i) begin
                    cnt_nxt = cnt_r + IBA_CNT_ONE;
                    if (cnt_nxt == need_r) begin
                        eng_nxt = ENG_IDLE;
                        done_w  = 1'b1;
                    end
                end
            end
            default: eng_nxt = ENG_IDLE;
        endcase
    end

    // ======================================================
    // Register decode.
    logic wr_bc1;
    logic wr_bc2;
    logic wr_pin;
    logic [31:0] rd_mux;

    assign wr_bc1 = reg_wr_i & (reg_addr_i == IBA_ADDR_BC1);
    assign wr_bc2 = reg_wr_i & (reg_addr_i == IBA_ADDR_BC2);
    assign wr_pin = reg_wr_i & (reg_addr_i == IBA_ADDR_PINCTL);

    // Unmapped addresses read as zero.
    always_comb begin
        rd_mux = '0;
        case (reg_addr_i)
            IBA_ADDR_BC1:    rd_mux = {30'h0, bus_release_enable_r,
                                       ext_write_buffer_enable_r};
            IBA_ADDR_BC2:    rd_mux = {30'h0, cpu_cycle_share_r,
                                       periph_write_buffer_enable_r};
            IBA_ADDR_PINCTL: rd_mux = {31'h0, pin_input_control_r};
            IBA_ADDR_STATUS: rd_mux = {25'h0, (eng_r != ENG_IDLE), pb_busy_r,
                                       (ext_r == EXT_MAST), (ext_r == EXT_REL), gnt_r};
            default:         rd_mux = '0;
        endcase
    end

    // ======================================================
    // Registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_write_buffer_enable_r    <= IBA_BC_RESET[IBA_BC1_WDB];
            bus_release_enable_r         <= IBA_BC_RESET[IBA_BC1_REL];
            periph_write_buffer_enable_r <= IBA_BC_RESET[IBA_BC2_PWDB];
            cpu_cycle_share_r            <= IBA_BC_RESET[IBA_BC2_SHARE];
            pin_input_control_r          <= IBA_PIN_RESET;
            rdata_r                      <= '0;
        end else begin
            if (wr_bc1) begin
                ext_write_buffer_enable_r <= reg_wdata_i[IBA_BC1_WDB];
                bus_release_enable_r      <= reg_wdata_i[IBA_BC1_REL];
            end
            if (wr_bc2) begin
                periph_write_buffer_enable_r <= reg_wdata_i[IBA_BC2_PWDB];
                cpu_cycle_share_r            <= reg_wdata_i[IBA_BC2_SHARE];
            end
            if (wr_pin) begin
                pin_input_control_r <= reg_wdata_i[IBA_PIN_ICR];
            end
            rdata_r <= reg_rd_i ? rd_mux : '0;
        end
    end

    // Arbiter and engine state.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnt_r  <= '0;
            ext_r  <= EXT_IDLE;
            eng_r  <= ENG_IDLE;
            cnt_r  <= IBA_CNT_ZERO;
            need_r <= IBA_CNT_ZERO;
            solo_r <= 1'b0;
        end else begin
            gnt_r <= gnt_nxt;
            ext_r <= ext_nxt;
            eng_r <= eng_nxt;
            cnt_r <= cnt_nxt;
            if (start) begin
                need_r <= need_w;
                solo_r <= buf_w;
            end
        end
    end

    // External write age and the peripheral write buffer.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_wr_cnt_r <= IBA_CNT_ZERO;
            pb_busy_r    <= 1'b0;
            pb_cnt_r     <= IBA_CNT_ZERO;
            pb_need_r    <= IBA_CNT_ZERO;
        end else begin
            if (!ext_wr_act) begin
                ext_wr_cnt_r <= IBA_CNT_ZERO;
            end else if (ext_wr_cnt_r < IBA_SOLO_CYC) begin
                ext_wr_cnt_r <= ext_wr_cnt_r + IBA_CNT_ONE;
            end
            if (start && buf_w) begin
                pb_busy_r <= 1'b1;
                pb_cnt_r  <= IBA_CNT_ZERO;
                pb_need_r <= need_w;
            end else if (pb_busy_r && pclk_en_i) begin
                pb_cnt_r <= pb_cnt_r + IBA_CNT_ONE;
                if (pb_cnt_r + IBA_CNT_ONE == pb_need_r) begin
                    pb_busy_r <= 1'b0;
                end
            end
        end
    end

    // ======================================================
    // Outputs.
    assign reg_rdata_o = rdata_r;
    assign acc_done_o  = done_w;
    assign pbuf_busy_o = pb_busy_r;
    // Internal grants stay live while released.
    assign int_gnt_o   = gnt_r;
    assign ext_gnt_o   = (ext_r == EXT_MAST) ? gnt_r : '0;
    assign pins_o.back_n  = ~(ext_r == EXT_REL);
    assign pins_o.addr_oe = ~(ext_r == EXT_REL);
    assign pins_o.data_oe = ext_wr_act;
    assign pins_o.ctrl_oe = ~(ext_r == EXT_REL);

endmodule
`default_nettype wire

// File: include/iba_pkg.sv
`default_nettype none
package iba_pkg;
    // ======================================================
    // Register map, word aligned byte addresses.
    localparam logic [7:0] IBA_ADDR_BC1    = 8'h00;
    localparam logic [7:0] IBA_ADDR_BC2    = 8'h04;
    localparam logic [7:0] IBA_ADDR_PINCTL = 8'h08;
    localparam logic [7:0] IBA_ADDR_STATUS = 8'h0C;
    // Field positions.
    localparam int IBA_BC1_WDB   = 0;
    localparam int IBA_BC1_REL   = 1;
    localparam int IBA_BC2_PWDB  = 0;
    localparam int IBA_BC2_SHARE = 1;
    localparam int IBA_PIN_ICR   = 0;
    localparam logic [1:0] IBA_BC_RESET  = 2'h0;
    localparam logic       IBA_PIN_RESET = 1'h0;
    // ======================================================
    // Master indices, highest priority has the highest index.
    localparam int IBA_M_CPU = 0;
    localparam int IBA_M_DTC = 1;
    localparam int IBA_M_DMA = 2;
    localparam int IBA_NM    = 3;
    // ======================================================
    // Access cycle counts.
    localparam logic [2:0] IBA_ROM_RD   = 3'h1;
    localparam logic [2:0] IBA_ROM_WR   = 3'h6;
    localparam logic [2:0] IBA_RAM_RD   = 3'h1;
    localparam logic [2:0] IBA_RAM_WR   = 3'h1;
    localparam logic [2:0] IBA_SYS_RD   = 3'h2;
    localparam logic [2:0] IBA_SYS_WR   = 3'h3;
    localparam logic [2:0] IBA_PFW_RD   = 3'h2;
    localparam logic [2:0] IBA_PFW_WR   = 3'h3;
    localparam logic [2:0] IBA_PER_RD   = 3'h2;
    localparam logic [2:0] IBA_PER_WR   = 3'h2;
    localparam logic [2:0] IBA_SOLO_CYC = 3'h2;
    localparam logic [2:0] IBA_CNT_ONE  = 3'h1;
    localparam logic [2:0] IBA_CNT_ZERO = 3'h0;
    // ======================================================
    typedef enum logic [2:0] {
        IBA_SP_ROM = 3'h0,
        IBA_SP_RAM = 3'h1,
        IBA_SP_SYS = 3'h2,
        IBA_SP_PFW = 3'h3,
        IBA_SP_PER = 3'h4,
        IBA_SP_EXT = 3'h5
    } iba_space_type;

    typedef struct packed {
        logic req;
        logic ext;
        logic wr;
        logic lock;
        logic hold;
        logic cyc_end;
    } iba_mreq_type;

    typedef struct packed {
        logic          valid;
        logic          wr;
        iba_space_type space;
    } iba_acc_type;

    typedef struct packed {
        logic addr_oe;
        logic data_oe;
        logic ctrl_oe;
        logic back_n;
    } iba_pins_type;
endpackage
`default_nettype wire

// File: sim/iba_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks of the bus arbiter.
module iba_checker
    import iba_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic [7:0]        reg_addr_i,
    input wire logic [31:0]       reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire iba_mreq_type      mreq_i [IBA_NM],
    input wire logic              ext_bus_request_in_n_i,
    input wire iba_acc_type       acc_i,
    input wire logic              acc_ready_o,
    input wire logic              acc_done_o,
    input wire logic              pbuf_busy_o,
    input wire logic [IBA_NM-1:0] int_gnt_o,
    input wire logic [IBA_NM-1:0] ext_gnt_o,
    input wire iba_pins_type      pins_o
);
    logic [1:0] bc1_r;
    logic [1:0] bc2_r;
    logic       pin_r;
    wire        rel_q  = !ext_bus_request_in_n_i && bc1_r[IBA_BC1_REL] && pin_r;
    wire        acc_go = acc_i.valid && acc_ready_o;
    wire        is_rom = acc_go && acc_i.space == IBA_SP_ROM;
    wire        is_sys = acc_go && acc_i.space == IBA_SP_SYS;

    // Shadow copies of the control bits.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bc1_r <= IBA_BC_RESET;
            bc2_r <= IBA_BC_RESET;
            pin_r <= IBA_PIN_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == IBA_ADDR_BC1) bc1_r <= reg_wdata_i[1:0];
            if (reg_addr_i == IBA_ADDR_BC2) bc2_r <= reg_wdata_i[1:0];
            if (reg_addr_i == IBA_ADDR_PINCTL) pin_r <= reg_wdata_i[IBA_PIN_ICR];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_onehot;
        $onehot0(int_gnt_o) && $onehot0(ext_gnt_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("grant not one-hot");
    property p_ext_int;
        (ext_gnt_o & ~int_gnt_o) == '0;
    endproperty
    a_ext_int: assert property (p_ext_int) else $error("ext grant alone");
    property p_rel_pins;
        !pins_o.back_n |-> !pins_o.addr_oe && !pins_o.ctrl_oe && !pins_o.data_oe && ext_gnt_o == '0;
    endproperty
    a_rel_pins: assert property (p_rel_pins) else $error("released bus still driven");
    property p_rel_cause;
        $fell(pins_o.back_n) |-> $past(rel_q);
    endproperty
    a_rel_cause: assert property (p_rel_cause) else $error("stray release");
    property p_rel_first;
        pins_o.back_n && ext_gnt_o == '0 && rel_q |=> !pins_o.back_n;
    endproperty
    a_rel_first: assert property (p_rel_first) else $error("release request lost");
    property p_ram;
        acc_go && acc_i.space == IBA_SP_RAM |-> acc_done_o;
    endproperty
    a_ram: assert property (p_ram) else $error("ram length");
    property p_rom_wr;
        is_rom && acc_i.wr |-> !acc_done_o [*5] ##1 acc_done_o;
    endproperty
    a_rom_wr: assert property (p_rom_wr) else $error("rom write length");
    property p_sys_wr;
        is_sys && acc_i.wr |-> !acc_done_o [*2] ##1 acc_done_o;
    endproperty
    a_sys_wr: assert property (p_sys_wr) else $error("sys write length");
    property p_sys_rd;
        is_sys && !acc_i.wr |-> !acc_done_o ##1 acc_done_o;
    endproperty
    a_sys_rd: assert property (p_sys_rd) else $error("sys read length");
    property p_pbuf;
        $rose(pbuf_busy_o) |-> $past(bc2_r[IBA_BC2_PWDB]);
    endproperty
    a_pbuf: assert property (p_pbuf) else $error("pbuf used while off");
    property p_wdb_off;
        !bc1_r[IBA_BC1_WDB] && pins_o.data_oe && acc_i.valid && acc_i.space != IBA_SP_EXT
            |-> !acc_ready_o;
    endproperty
    a_wdb_off: assert property (p_wdb_off) else $error("overlap with buffer off");
    property p_cpu_lock;
        int_gnt_o[IBA_M_CPU] && mreq_i[IBA_M_CPU].req && mreq_i[IBA_M_CPU].lock
            |=> int_gnt_o[IBA_M_CPU];
    endproperty
    a_cpu_lock: assert property (p_cpu_lock) else $error("locked processor lost bus");
    property p_dma_lock;
        int_gnt_o[IBA_M_DMA] && mreq_i[IBA_M_DMA].req && mreq_i[IBA_M_DMA].lock
            |=> int_gnt_o[IBA_M_DMA];
    endproperty
    a_dma_lock: assert property (p_dma_lock) else $error("dma lost bus mid pair");
endmodule

bind iba_arbiter iba_checker u_chk (.*);
`default_nettype wire

// File: sim/iba_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bus masters, driven by level commands.
module iba_master_model
    import iba_pkg::*;
#(
    parameter int CYC_LEN = 5
)
(
    input  wire logic [IBA_NM-1:0] want_i,
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [IBA_NM-1:0] ext_i,
    input  wire logic [IBA_NM-1:0] wr_i,
    input  wire logic [IBA_NM-1:0] lock_i,
    input  wire logic [IBA_NM-1:0] hold_i,
    input  wire logic              rel_req_i,
    input  wire logic [IBA_NM-1:0] int_gnt_i,
    output var iba_mreq_type       mreq_o [IBA_NM],
    output logic                   ext_bus_request_in_n_o
);
    logic [3:0] cnt_r [IBA_NM];

    // A master times its bus cycle only while it owns the bus.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        for (int m = 0; m < IBA_NM; m++) begin
            if (!rst_n_i || !int_gnt_i[m] || cnt_r[m] == 4'(CYC_LEN - 1)) cnt_r[m] <= 4'h0;
            else cnt_r[m] <= cnt_r[m] + 4'h1;
        end
    end

    // External space is asked for only after the internal bus is won.
    always_comb begin
        for (int m = 0; m < IBA_NM; m++) begin
            mreq_o[m].req     = want_i[m];
            mreq_o[m].ext     = ext_i[m] && int_gnt_i[m];
            mreq_o[m].wr      = wr_i[m];
            mreq_o[m].lock    = lock_i[m];
            mreq_o[m].hold    = hold_i[m];
            mreq_o[m].cyc_end = int_gnt_i[m] && cnt_r[m] == 4'(CYC_LEN - 1);
        end
    end

    // The external master holds its pin low while it asks.
    assign ext_bus_request_in_n_o = !rel_req_i;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import iba_pkg::*;
    logic              clk_i = 1'b0;
    logic              pclk_en_i = 1'b0;
    logic              rst_n_i, reg_wr_i, reg_rd_i, sleep_i, pin_n;
    logic [7:0]        reg_addr_i;
    logic [31:0]       reg_wdata_i, reg_rdata_o;
    logic [1:0]        pcnt = 2'h0;
    logic [2:0]        want, ext, wr, lock, hold, int_gnt_o, ext_gnt_o;
    logic              rel_req, acc_ready_o, acc_done_o, pbuf_busy_o;
    iba_mreq_type      mreq [IBA_NM];
    iba_acc_type       acc_i;
    iba_pins_type      pins_o;
    int                err_count = 0, n_tests = 0, cyc_cnt = 0;

    iba_arbiter u_dut (.*, .mreq_i(mreq), .ext_bus_request_in_n_i(pin_n));
    iba_master_model u_mst (.want_i(want), .clk_i(clk_i), .rst_n_i(rst_n_i), .ext_i(ext),
        .wr_i(wr), .lock_i(lock), .hold_i(hold), .rel_req_i(rel_req), .int_gnt_i(int_gnt_o),
        .mreq_o(mreq), .ext_bus_request_in_n_o(pin_n));

    // Clock, a divide-by-four peripheral enable, and a hang limit.
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        pcnt <= pcnt + 2'h1;
        pclk_en_i <= (pcnt == 2'h2);
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task print_verdict;
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task reg_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        `CHK(nm, e, reg_rdata_o)
        @(posedge clk_i);
    endtask

    // Counts cycles, or enable pulses, until done.
    task acc(input iba_space_type sp, input logic w, input int e, input logic by_pulse);
        int cyc, pl;
        logic dn;
        pl = 0;
        acc_i <= '{valid: 1'b1, wr: w, space: sp};
        repeat (40) @(negedge clk_i) if (acc_ready_o === 1'b1) break;
        cyc = 1;
        dn = acc_done_o;
        @(posedge clk_i);
        acc_i <= '0;
        while (dn !== 1'b1 && cyc < 40) begin
            @(negedge clk_i);
            cyc++;
            pl += int'(pclk_en_i);
            dn = acc_done_o;
        end
        `CHK("access", e, by_pulse ? pl : cyc)
        @(posedge clk_i);
    endtask

    task wait_gnt(input logic [2:0] e, input bit any);
        repeat (30) @(negedge clk_i) if (any ? int_gnt_o != 3'h0 : int_gnt_o === e) break;
        `CHK("int_gnt", e, int_gnt_o)
        @(posedge clk_i);
    endtask

    // ==========================================
    // Main sequence.
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, sleep_i, rel_req} = '0;
        {reg_addr_i, reg_wdata_i, want, ext, wr, lock, hold} = '0;
        acc_i = '0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 4; i++) reg_rd(8'(4 * i), 32'h0, "reset");
        reg_wr(8'h10, 32'hFFFF_FFFF);
        reg_rd(8'h10, 32'h0, "unmapped");
        reg_wr(IBA_ADDR_BC2, 32'h3);
        reg_rd(IBA_ADDR_BC2, 32'h3, "bc2");
        reg_wr(IBA_ADDR_BC2, 32'h0);
        acc(IBA_SP_ROM, 1'b0, 1, 1'b0);
        acc(IBA_SP_ROM, 1'b1, 6, 1'b0);
        acc(IBA_SP_RAM, 1'b0, 1, 1'b0);
        acc(IBA_SP_RAM, 1'b1, 1, 1'b0);
        acc(IBA_SP_SYS, 1'b0, 2, 1'b0);
        acc(IBA_SP_SYS, 1'b1, 3, 1'b0);
        acc(IBA_SP_PFW, 1'b0, 2, 1'b1);
        acc(IBA_SP_PFW, 1'b1, 3, 1'b1);
        acc(IBA_SP_PER, 1'b0, 2, 1'b1);
        acc(IBA_SP_PER, 1'b1, 2, 1'b1);
        reg_wr(IBA_ADDR_BC2, 32'h1);
        acc(IBA_SP_PER, 1'b1, 2, 1'b0);
        @(negedge clk_i);
        `CHK("pbuf_busy", 1'b1, pbuf_busy_o)
        @(posedge clk_i);
        acc(IBA_SP_RAM, 1'b1, 1, 1'b0);
        repeat (20) @(negedge clk_i) if (pbuf_busy_o === 1'b0) break;
        `CHK("pbuf_idle", 1'b0, pbuf_busy_o)
        @(posedge clk_i);
        acc(IBA_SP_PFW, 1'b1, 3, 1'b1);
        reg_wr(IBA_ADDR_BC2, 32'h0);
        // Arbitration.
        want <= 3'b001;
        wait_gnt(3'b001, 1'b0);
        sleep_i <= 1'b1;
        want <= 3'b101;
        repeat (2) @(negedge clk_i);
        `CHK("sleep_gnt", 3'b100, int_gnt_o)
        @(posedge clk_i);
        sleep_i <= 1'b0;
        want <= 3'b011;
        wait_gnt(3'b010, 1'b0);
        want <= 3'b000;
        wait_gnt(3'b000, 1'b0);
        want <= 3'b011;
        wait_gnt(3'b010, 1'b1);
        want <= 3'b000;
        wait_gnt(3'b000, 1'b0);
        want <= 3'b101;
        hold <= 3'b100;
        lock <= 3'b100;
        wait_gnt(3'b100, 1'b1);
        repeat (12) @(posedge clk_i);
        wait_gnt(3'b100, 1'b0);
        lock <= 3'b001;
        reg_wr(IBA_ADDR_BC2, 32'h2);
        wait_gnt(3'b001, 1'b0);
        reg_wr(IBA_ADDR_BC2, 32'h0);
        repeat (10) @(posedge clk_i);
        wait_gnt(3'b001, 1'b0);
        lock <= 3'b000;
        wait_gnt(3'b100, 1'b0);
        {want, hold} <= '0;
        wait_gnt(3'b000, 1'b0);
        // External release.
        reg_wr(IBA_ADDR_BC1, 32'h2);
        rel_req <= 1'b1;
        repeat (6) @(negedge clk_i);
        `CHK("back_n", 1'b1, pins_o.back_n)
        @(posedge clk_i);
        reg_wr(IBA_ADDR_PINCTL, 32'h1);
        repeat (10) @(negedge clk_i) if (pins_o.back_n === 1'b0) break;
        `CHK("back_n", 1'b0, pins_o.back_n)
        `CHK("addr_oe", 1'b0, pins_o.addr_oe)
        @(posedge clk_i);
        want <= 3'b001;
        ext <= 3'b001;
        acc(IBA_SP_RAM, 1'b0, 1, 1'b0);
        repeat (4) @(negedge clk_i);
        `CHK("ext_gnt", 3'b000, ext_gnt_o)
        @(posedge clk_i);
        rel_req <= 1'b0;
        repeat (20) @(negedge clk_i) if (ext_gnt_o === 3'b001) break;
        `CHK("ext_gnt", 3'b001, ext_gnt_o)
        // External write overlap, buffer off then on.
        @(posedge clk_i);
        wr <= 3'b001;
        acc_i <= '{valid: 1'b1, wr: 1'b0, space: IBA_SP_RAM};
        repeat (20) @(negedge clk_i) if (pins_o.data_oe === 1'b1) break;
        `CHK("ready_off", 1'b0, acc_ready_o)
        @(posedge clk_i);
        acc_i <= '0;
        reg_wr(IBA_ADDR_BC1, 32'h3);
        acc_i <= '{valid: 1'b1, wr: 1'b0, space: IBA_SP_RAM};
        repeat (20) @(negedge clk_i) if (acc_ready_o === 1'b1 && pins_o.data_oe === 1'b1) break;
        `CHK("ready_on", 1'b1, acc_ready_o && pins_o.data_oe)
        @(posedge clk_i);
        acc_i <= '0;
        {want, ext, wr} <= '0;
        repeat (4) @(posedge clk_i);
        print_verdict();
    end
endmodule
`default_nettype wire
